// ==== pkg/tsi_port_pkg.sv ====
// Shared constants and types for the host port and output control block
package tsi_port_pkg;
  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [3:0] REGION_REGS = 4'h0;
  localparam logic [3:0] REGION_CMEM = 4'h1;
  localparam logic [3:0] CMEM_PAGE = 4'h0;
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_RATE_LO = 12'h001;
  localparam logic [11:0] OFS_RATE_HI = 12'h002;
  localparam logic [11:0] OFS_STATUS = 12'h003;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int CTRL_STANDBY = 0;
  localparam int CTRL_INDICATE = 1;
  localparam int STAT_FORMAT = 0;
  localparam int STAT_DRIVE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [11:0] RATE_RESET = 12'h000;
  localparam logic MODE_SYNC = 1'b1;
  localparam logic FORMAT_GCI = 1'b1;
  // ----------------------------------------
  // Receive rate codes
  // ----------------------------------------
  localparam logic [2:0] RATE_2M = 3'h0;
  localparam logic [2:0] RATE_4M = 3'h1;
  localparam logic [2:0] RATE_8M = 3'h2;
  localparam logic [2:0] RATE_16M = 3'h3;
  localparam logic [2:0] RATE_32M = 3'h4;
  localparam logic [3:0] DIV_2M = 4'hf;
  localparam logic [3:0] DIV_4M = 4'h7;
  localparam logic [3:0] DIV_8M = 4'h3;
  localparam logic [3:0] DIV_16M = 4'h1;
  localparam logic [3:0] DIV_32M = 4'h0;
  // ----------------------------------------
  // Sizes and counts
  // ----------------------------------------
  localparam int STREAMS = 64;
  localparam int GROUPS = 8;
  localparam int GROUP_SIZE = 8;
  localparam int RATE_W = 3;
  localparam int CHAN_W = 6;
  localparam int CHAN_LSB = 3;
  localparam int BITCNT_W = 12;
  localparam logic [3:0] IDLE_SAME = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_LOAD, ST_HOLD, ST_RELEASE
  } bus_state_t;
endpackage

// ==== rtl/hiz_memory.sv ====
// Per-channel high-impedance control memory, four 16-bit lanes per channel
module hiz_memory
  import tsi_port_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Processor side
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  // Output side
  input wire logic [CHAN_W-1:0] chan,
  output logic [STREAMS-1:0] hiz_bits
);
  logic [15:0] mem [0:255];

  // ----------------------------------------
  // Storage, cleared by reset so outputs never float unknown
  // ----------------------------------------
  for (genvar w = 0; w < 256; w++)
  begin : g_word
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        mem[w] <= 16'h0000;
      else if (cpu_wr && cpu_addr == 8'(w))
        mem[w] <= cpu_wdata;
    end
  end

  // ----------------------------------------
  // Registered read ports
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_rdata <= 16'h0000;
      hiz_bits <= '0;
    end
    else
    begin
      cpu_rdata <= mem[cpu_addr];
      for (int l = 0; l < 4; l++)
        hiz_bits[l*16 +: 16] <= mem[{chan, 2'(l)}];
    end
  end
endmodule

// ==== rtl/tsi_host_port_output_control.sv ====
// Processor port, receive timing and transmit drive control
// How it works
// - Full 16-bit address decoded into register and memory regions
// - Port only reacts while chip select is low
// - Access starts only with strobe and chip select both low
// - Read drives data bus, write samples it
// - Strap picks synchronous or asynchronous bus timing
// - Synchronous mode: low byte driven only with low byte enable
// - Synchronous mode: ack pin is high byte enable input
// - Asynchronous mode: ack driven low when transfer done
// - Asynchronous cycle end: ack driven high, then released
// - Drive enable low and standby low float all transmit outputs except odd group pins in indicator mode
// - Drive enable high turns transmit drivers on
// - Per-channel memory bit still floats its stream, except odd group pins in indicator mode
// - Reset clears state, floats transmit and data outputs
// - Frame pulse polarity found automatically from idle level
// - Each receive group runs at one of five selected rates
// - Indicator mode: odd group pins show stream drive status
module tsi_host_port_output_control
  import tsi_port_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Processor bus
  input wire logic [15:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_lo,
  output logic data_oe_hi,
  input wire logic chip_select_n,
  input wire logic data_strobe_n,
  input wire logic read_not_write,
  input wire logic bus_timing_select,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  output logic transfer_ack_n,
  output logic transfer_ack_oe,
  // Serial timing
  input wire logic serial_bit_clock,
  input wire logic frame_sync_pulse,
  output logic [GROUPS-1:0] rx_bit_enable,
  output logic frame_format,
  // Transmit drive
  input wire logic tx_drive_enable,
  input wire logic [STREAMS-1:0] tx_data_in,
  output logic [STREAMS-1:0] tx_pin_out,
  output logic [STREAMS-1:0] tx_pin_oe
);
  logic rst_meta_q, rst_q;
  bus_state_t state_q, state_d;
  logic [15:0] addr_q, addr_d, wdata_q, wdata_d, dout_d, rd_mux, cmem_rdata;
  logic rnw_q, rnw_d, oe_lo_d, oe_hi_d, ack_d, ack_oe_d, commit;
  logic [1:0] ctrl_q, ctrl_d;
  logic [11:0] rate_lo_q, rate_lo_d, rate_hi_q, rate_hi_d;
  logic sclk_prev_q, fs_prev_q, fs_prev_d, idle_q, idle_d, fmt_d;
  logic [3:0] same_q, same_d;
  logic [BITCNT_W-1:0] bit_q, bit_d;
  logic [STREAMS-1:0] hiz_bits, base_oe, tx_out_d, tx_oe_d;
  logic [GROUPS-1:0] rx_en_d;
  logic [RATE_W*GROUPS-1:0] rates;
  logic qual, sync, sel_regs, sel_mem, sclk_edge, frame_start;

  assign qual = !chip_select_n && !data_strobe_n;
  assign sync = bus_timing_select == MODE_SYNC;
  assign sel_regs = addr_q[15:12] == REGION_REGS;
  assign sel_mem = addr_q[15:12] == REGION_CMEM && addr_q[11:8] == CMEM_PAGE;
  assign rates = {rate_hi_q, rate_lo_q};

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rnw_d = rnw_q;
    dout_d = data_out;
    oe_lo_d = data_oe_lo;
    oe_hi_d = data_oe_hi;
    ack_d = transfer_ack_n;
    ack_oe_d = transfer_ack_oe;
    commit = 1'b0;
    case (state_q)
      ST_IDLE:
        if (qual)
        begin
          addr_d = addr;
          wdata_d = data_in;
          rnw_d = read_not_write;
          state_d = ST_FETCH;
        end
      ST_FETCH, ST_LOAD, ST_HOLD:
        if (!qual)
        begin
          commit = !rnw_q;
          oe_lo_d = 1'b0;
          oe_hi_d = 1'b0;
          if (!sync)
          begin
            ack_d = 1'b1;
            ack_oe_d = 1'b1;
            state_d = ST_RELEASE;
          end
          else
            state_d = ST_IDLE;
        end
        else
        begin
          if (!rnw_q)
          begin
            addr_d = addr;
            wdata_d = data_in;
          end
          if (state_q == ST_FETCH)
            state_d = ST_LOAD;
          else
          begin
            if (state_q == ST_LOAD)
              dout_d = rd_mux;
            // Byte enables are ignored in async mode, so a read drives both lanes
            oe_lo_d = rnw_q && (!sync || !low_byte_enable_n);
            oe_hi_d = rnw_q && (!sync || !high_byte_enable_n);
            ack_d = 1'b0;
            ack_oe_d = !sync;
            state_d = ST_HOLD;
          end
        end
      ST_RELEASE:
      begin
        ack_oe_d = 1'b0;
        ack_d = 1'b1;
        state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      state_q <= ST_IDLE;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      rnw_q <= 1'b1;
      data_out <= 16'h0000;
      data_oe_lo <= 1'b0;
      data_oe_hi <= 1'b0;
      transfer_ack_n <= 1'b1;
      transfer_ack_oe <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rnw_q <= rnw_d;
      data_out <= dout_d;
      data_oe_lo <= oe_lo_d;
      data_oe_hi <= oe_hi_d;
      transfer_ack_n <= ack_d;
      transfer_ack_oe <= ack_oe_d;
    end
  end

  // ----------------------------------------
  // Registers and read data
  // ----------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    rate_lo_d = rate_lo_q;
    rate_hi_d = rate_hi_q;
    rd_mux = 16'h0000;
    if (commit && sel_regs)
      case (addr_q[11:0])
        OFS_CONTROL: ctrl_d = wdata_q[1:0];
        OFS_RATE_LO: rate_lo_d = wdata_q[11:0];
        OFS_RATE_HI: rate_hi_d = wdata_q[11:0];
        default: ;
      endcase
    if (sel_mem)
      rd_mux = cmem_rdata;
    else if (sel_regs)
      case (addr_q[11:0])
        OFS_CONTROL: rd_mux = {14'h0000, ctrl_q};
        OFS_RATE_LO: rd_mux = {4'h0, rate_lo_q};
        OFS_RATE_HI: rd_mux = {4'h0, rate_hi_q};
        OFS_STATUS:
        begin
          rd_mux[STAT_FORMAT] = frame_format;
          rd_mux[STAT_DRIVE] = tx_drive_enable;
        end
        default: rd_mux = 16'h0000;
      endcase
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      ctrl_q <= CTRL_RESET;
      rate_lo_q <= RATE_RESET;
      rate_hi_q <= RATE_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rate_lo_q <= rate_lo_d;
      rate_hi_q <= rate_hi_d;
    end
  end

  hiz_memory u_hiz_memory (
    .mclk(mclk),
    .rst_n(rst_q),
    .cpu_addr(addr_q[7:0]),
    .cpu_wr(commit && sel_mem),
    .cpu_wdata(wdata_q),
    .cpu_rdata(cmem_rdata),
    .chan(bit_q[CHAN_LSB +: CHAN_W]),
    .hiz_bits(hiz_bits)
  );

  // ----------------------------------------
  // Frame pulse and receive rates
  // ----------------------------------------
  // Serial clock is only sampled, so it must run slower than mclk / 2
  assign sclk_edge = serial_bit_clock && !sclk_prev_q;
  assign frame_start = sclk_edge && frame_sync_pulse != idle_q
    && fs_prev_q == idle_q;

  always_comb
  begin
    fs_prev_d = fs_prev_q;
    same_d = same_q;
    idle_d = idle_q;
    bit_d = bit_q;
    fmt_d = frame_format;
    if (sclk_edge)
    begin
      fs_prev_d = frame_sync_pulse;
      bit_d = frame_start ? '0 : bit_q + 1'b1;
      if (frame_sync_pulse != fs_prev_q)
        same_d = 4'h0;
      else if (same_q != IDLE_SAME)
        same_d = same_q + 4'h1;
      // A long quiet level is the idle level; its opposite marks frames.
      // The sample that breaks the run must not be learned as idle.
      if (same_q == IDLE_SAME && frame_sync_pulse == fs_prev_q)
        idle_d = frame_sync_pulse;
      if (frame_start)
        fmt_d = idle_q ? ~FORMAT_GCI : FORMAT_GCI;
    end
  end

  for (genvar g = 0; g < GROUPS; g++)
  begin : g_rate
    logic [RATE_W-1:0] code;
    logic [3:0] div;
    assign code = rates[g*RATE_W +: RATE_W];
    always_comb
    begin
      case (code)
        RATE_4M: div = DIV_4M;
        RATE_8M: div = DIV_8M;
        RATE_16M: div = DIV_16M;
        RATE_32M: div = DIV_32M;
        default: div = DIV_2M;
      endcase
    end
    assign rx_en_d[g] = sclk_edge && (bit_d[3:0] & div) == 4'h0;
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      sclk_prev_q <= 1'b0;
      fs_prev_q <= 1'b1;
      same_q <= 4'h0;
      idle_q <= 1'b1;
      bit_q <= '0;
      frame_format <= 1'b0;
      rx_bit_enable <= '0;
    end
    else
    begin
      sclk_prev_q <= serial_bit_clock;
      fs_prev_q <= fs_prev_d;
      same_q <= same_d;
      idle_q <= idle_d;
      bit_q <= bit_d;
      frame_format <= fmt_d;
      rx_bit_enable <= rx_en_d;
    end
  end

  // ----------------------------------------
  // Transmit drive control
  // ----------------------------------------
  for (genvar k = 0; k < STREAMS; k++)
  begin : g_tx
    assign base_oe[k] = (tx_drive_enable || ctrl_q[CTRL_STANDBY])
      && !hiz_bits[k];
    if ((k / GROUP_SIZE) % 2 == 1)
    begin : g_ind
      assign tx_out_d[k] = ctrl_q[CTRL_INDICATE] ? base_oe[k-GROUP_SIZE]
        : tx_data_in[k];
      assign tx_oe_d[k] = ctrl_q[CTRL_INDICATE] || base_oe[k];
    end
    else
    begin : g_plain
      assign tx_out_d[k] = tx_data_in[k];
      assign tx_oe_d[k] = base_oe[k];
    end
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      tx_pin_out <= '0;
      tx_pin_oe <= '0;
    end
    else
    begin
      tx_pin_out <= tx_out_d;
      tx_pin_oe <= tx_oe_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_q);

  sequence s_async_start;
    state_q == ST_IDLE && qual && !sync;
  endsequence
  sequence s_held;
    qual [*3];
  endsequence

  a_cs_gate: assert property (state_q == ST_IDLE && chip_select_n |=> state_q == ST_IDLE) else $error("access without chip select");
  a_strobe_gate: assert property (state_q == ST_IDLE && data_strobe_n |=> state_q == ST_IDLE) else $error("access without strobe");
  a_read_dir: assert property ((data_oe_lo || data_oe_hi) |-> rnw_q && state_q == ST_HOLD) else $error("data driven outside read");
  a_low_byte: assert property (sync && data_oe_lo |-> $past(!low_byte_enable_n)) else $error("low byte driven without enable");
  a_high_byte: assert property (sync |-> !transfer_ack_oe && (!data_oe_hi || $past(!high_byte_enable_n))) else $error("high byte or ack pin misuse");
  a_ack_low: assert property (s_async_start ##0 s_held |=> transfer_ack_oe && !transfer_ack_n) else $error("ack not driven low");
  a_ack_release: assert property (transfer_ack_oe && transfer_ack_n |=> !transfer_ack_oe) else $error("ack not released after high");
  a_tx_standby: assert property (!tx_drive_enable && !ctrl_q[CTRL_STANDBY] |=> tx_pin_oe[7:0] == 8'h00) else $error("transmit not floated");
  a_tx_enable: assert property (tx_drive_enable && !hiz_bits[0] |=> tx_pin_oe[0]) else $error("transmit driver not enabled");
  a_tx_chan_hiz: assert property (hiz_bits[0] |=> !tx_pin_oe[0]) else $error("channel not floated");
  a_reset_float: assert property (@(posedge mclk) disable iff (1'b0) !rst_q |-> tx_pin_oe == '0 && !data_oe_lo && !data_oe_hi) else $error("outputs driven in reset");
  a_write_commit: assert property (state_q == ST_HOLD && !qual && !rnw_q |-> commit ##1 state_q != ST_HOLD) else $error("write not committed at strobe end");
endmodule

// ==== bench/cpu_bus_model.sv ====
// Processor bus master model facing the host port
module cpu_bus_model
  import tsi_port_pkg::*;
(
  // Clock and strap
  input wire logic mclk,
  input wire logic bus_timing_select,
  // Device outputs
  input wire logic [15:0] data_out,
  input wire logic data_oe_lo,
  input wire logic data_oe_hi,
  input wire logic transfer_ack_n,
  input wire logic transfer_ack_oe,
  // Bus drive
  output logic [15:0] addr,
  output logic [15:0] data_in,
  output logic chip_select_n,
  output logic data_strobe_n,
  output logic read_not_write,
  output logic low_byte_enable_n,
  output logic high_byte_enable_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] wd;
  logic hbe_n;
  logic lbe_n;
  initial
  begin
    addr = 16'hffff;
    wd = 16'hffff;
    chip_select_n = 1'b1;
    data_strobe_n = 1'b1;
    read_not_write = 1'b1;
    hbe_n = 1'b1;
    lbe_n = 1'b0;
  end
  // No pull on the data bus, so a released lane carries the model's wd value, which is inverted between accesses
  assign data_in[15:8] = data_oe_hi ? data_out[15:8] : wd[15:8];
  assign data_in[7:0] = data_oe_lo ? data_out[7:0] : wd[7:0];
  // Shared pin: pull-up holds it high when nobody drives
  assign high_byte_enable_n = transfer_ack_oe ? transfer_ack_n :
    (bus_timing_select ? hbe_n : 1'b1);
  assign low_byte_enable_n = bus_timing_select ? lbe_n : 1'b0;
  task automatic access(input logic rnw, input logic [15:0] a, d,
    output logic [15:0] rd, output logic [1:0] oe, output logic ok, hi);
    ok = 1'b0;
    hi = 1'b0;
    rd = 16'h0000;
    oe = 2'b00;
    addr = a;
    wd = d;
    read_not_write = rnw;
    chip_select_n = 1'b0;
    data_strobe_n = 1'b0;
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(posedge mclk);
      if (bus_timing_select ? n == 4 :
        (transfer_ack_oe === 1'b1 && transfer_ack_n === 1'b0))
      begin
        ok = 1'b1;
        rd = data_out;
        oe = {data_oe_hi, data_oe_lo};
      end
    end
    #1;
    data_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    addr = ~a;
    wd = ~d;
    repeat (4)
    begin
      @(posedge mclk);
      hi |= transfer_ack_oe === 1'b1 && transfer_ack_n === 1'b1;
    end
    hi &= transfer_ack_oe === 1'b0;
    #1;
  endtask
endmodule

// ==== bench/tsi_host_port_output_control_test.sv ====
// Self-checking bench for the host port and output control block
module tsi_host_port_output_control_test
  import tsi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Signals
  // ------
  localparam logic [15:0] CTRL_A = {REGION_REGS, OFS_CONTROL};
  localparam logic [15:0] RLO_A = {REGION_REGS, OFS_RATE_LO};
  localparam logic [15:0] RHI_A = {REGION_REGS, OFS_RATE_HI};
  localparam logic [15:0] STAT_A = {REGION_REGS, OFS_STATUS};
  localparam logic [63:0] M = 64'hffff_ffff_ffff_fff7;
  typedef struct {logic rnw; logic [15:0] a; logic [15:0] d;} row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic bus_timing_select = 1'b0;
  logic serial_bit_clock = 1'b0;
  logic frame_sync_pulse = 1'b1;
  logic tx_drive_enable = 1'b0;
  logic [63:0] tx_data_in = 64'h5a5a_5a5a_5a5a_5a5a;
  logic [15:0] addr, data_in, data_out, rd;
  logic chip_select_n, data_strobe_n, read_not_write;
  logic low_byte_enable_n, high_byte_enable_n;
  logic data_oe_lo, data_oe_hi, transfer_ack_n, transfer_ack_oe;
  logic [7:0] rx_bit_enable;
  logic frame_format, ok, hi;
  logic [1:0] oe;
  logic [63:0] tx_pin_out, tx_pin_oe;
  logic counting = 1'b0;
  int bad_count = 0;
  int n_checks = 0;
  int cnt [8] = '{default: 0};
  int exp_cnt [8] = '{64, 4, 8, 16, 32, 4, 4, 4};
  row_t rows [14] = '{
    '{1'b0, CTRL_A, 16'hffff}, '{1'b1, CTRL_A, 16'h0003},
    '{1'b0, CTRL_A, 16'h0000}, '{1'b1, CTRL_A, 16'h0000},
    '{1'b0, RLO_A, 16'hffff}, '{1'b1, RLO_A, 16'h0fff},
    '{1'b0, RHI_A, 16'h1234}, '{1'b1, RHI_A, 16'h0234},
    '{1'b0, STAT_A, 16'hffff}, '{1'b1, STAT_A, 16'h0002},
    '{1'b0, 16'h2000, 16'habcd}, '{1'b1, 16'h2000, 16'h0000},
    '{1'b0, 16'h1004, 16'h5a5a}, '{1'b1, 16'h1004, 16'h5a5a}};
  always #50 mclk = ~mclk;
  always @(posedge mclk)
    if (counting)
      foreach (cnt[g])
        cnt[g] += rx_bit_enable[g];
  tsi_host_port_output_control DUT (.mclk, .reset_n, .addr, .data_in,
    .data_out, .data_oe_lo, .data_oe_hi, .chip_select_n, .data_strobe_n,
    .read_not_write, .bus_timing_select, .low_byte_enable_n,
    .high_byte_enable_n, .transfer_ack_n, .transfer_ack_oe,
    .serial_bit_clock, .frame_sync_pulse, .rx_bit_enable, .frame_format,
    .tx_drive_enable, .tx_data_in, .tx_pin_out, .tx_pin_oe);
  cpu_bus_model u_cpu (.mclk, .bus_timing_select, .data_out, .data_oe_lo,
    .data_oe_hi, .transfer_ack_n, .transfer_ack_oe, .addr, .data_in,
    .chip_select_n, .data_strobe_n, .read_not_write, .low_byte_enable_n,
    .high_byte_enable_n);
  // ------
  // Tasks
  // ------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h got %h", what, exp, got);
    end
  endtask
  // A bus cycle that never completes ends the run
  task automatic bus(input logic rnw, input logic [15:0] a, d);
    u_cpu.access(rnw, a, d, rd, oe, ok, hi);
    chk("done", 64'h1, {63'h0, ok});
    if (ok !== 1'b1)
      stop_test();
  endtask
  // Frame level set in the low phase so the rising edge sees it settled
  task automatic sclk(input int n, input logic fs);
    repeat (n)
    begin
      serial_bit_clock = 1'b0;
      frame_sync_pulse = fs;
      tick(2);
      serial_bit_clock = 1'b1;
      tick(2);
    end
  endtask
  task automatic do_reset;
    reset_n = 1'b0;
    tick(12);
    chk("tx oe", 64'h0, tx_pin_oe);
    chk("bus oe", 64'h0, {data_oe_hi, data_oe_lo, transfer_ack_oe});
    reset_n = 1'b1;
    tick(4);
  endtask
  task automatic done(input string s);
    $display("%s finished, mismatches %0d", s, bad_count);
  endtask
  // ------
  // Sequence
  // ------
  initial
  begin
    do_reset();
    done("reset");
    for (int l = 0; l < 4; l++)
      bus(1'b0, {REGION_CMEM, CMEM_PAGE, 6'h00, l[1:0]}, 16'h0000);
    bus(1'b0, 16'h1000, 16'h0008);
    tick(4);
    chk("off", 64'h0, tx_pin_oe);
    tx_drive_enable = 1'b1;
    tick(4);
    chk("on", M, tx_pin_oe);
    chk("tx data", tx_data_in & M, tx_pin_out & M);
    tx_drive_enable = 1'b0;
    bus(1'b0, CTRL_A, 16'h0001);
    tick(4);
    chk("standby", M, tx_pin_oe);
    bus(1'b0, CTRL_A, 16'h0003);
    tick(4);
    chk("ind oe", 64'hff, {56'h0, tx_pin_oe[15:8]});
    chk("ind", 64'hf7, {56'h0, tx_pin_out[15:8]});
    tx_drive_enable = 1'b1;
    done("drive");
    foreach (rows[i])
    begin
      bus(rows[i].rnw, rows[i].a, rows[i].d);
      chk("lanes", {62'h0, {2{rows[i].rnw}}}, {62'h0, oe});
      if (rows[i].rnw)
        chk("rdata", {48'h0, rows[i].d}, {48'h0, rd});
      chk("ack end", 64'h1, {63'h0, hi});
    end
    done("table");
    u_cpu.addr = CTRL_A;
    u_cpu.wd = 16'h0002;
    u_cpu.read_not_write = 1'b0;
    u_cpu.data_strobe_n = 1'b0;
    tick(6);
    chk("idle", 64'h0, {data_oe_lo, transfer_ack_oe});
    u_cpu.data_strobe_n = 1'b1;
    tick(2);
    bus(1'b1, CTRL_A, 16'h0000);
    chk("no write", 64'h0, {48'h0, rd});
    done("select");
    bus(1'b0, RLO_A, 16'h0444);
    bus(1'b0, RHI_A, 16'h003b);
    counting = 1'b1;
    sclk(64, 1'b1);
    tick(3);
    counting = 1'b0;
    foreach (cnt[g])
      chk("pulses", exp_cnt[g], cnt[g]);
    sclk(12, 1'b0);
    sclk(1, 1'b1);
    sclk(2, 1'b0);
    chk("format", {63'h0, FORMAT_GCI}, {63'h0, frame_format});
    bus(1'b1, STAT_A, 16'h0000);
    chk("status", 64'h3, {48'h0, rd});
    done("serial");
    bus_timing_select = MODE_SYNC;
    do_reset();
    for (int i = 0; i < 3; i++)
    begin
      u_cpu.lbe_n = i[0];
      u_cpu.hbe_n = i[1];
      bus(1'b1, CTRL_A, 16'h0000);
      chk("sync lanes", {62'h0, ~i[1], ~i[0]}, {62'h0, oe});
      chk("sync ack", 64'h0, {63'h0, hi});
      chk("ctrl", 64'h0, {48'h0, rd});
    end
    done("sync");
    stop_test();
  end
endmodule
